// ---- shared/crl_pkg.sv ----
// Constants shared by the communication-rail mapping register block.
package crl_pkg;

	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [6:0] CRL_IO_RAIL_OFFSET    = 7'h4A;
	localparam logic [6:0] CRL_RADIO_RAIL_OFFSET = 7'h4B;
	localparam logic [7:0] CRL_IO_RAIL_RESET     = 8'h24;
	localparam logic [7:0] CRL_RADIO_RAIL_RESET  = 8'h24;
	localparam logic [7:0] CRL_UNMAPPED_READ     = 8'h00;

	// -----------------------------------------------------------------
	// Field layout
	// -----------------------------------------------------------------
	localparam int CRL_STATE_LSB  = 0;
	localparam int CRL_STATE_MSB  = 2;
	localparam int CRL_EXIT_LSB   = 3;
	localparam int CRL_EXIT_MSB   = 5;
	localparam int CRL_SEL_LSB    = 6;
	localparam int CRL_SEL_MSB    = 7;

	// -----------------------------------------------------------------
	// Codes
	// -----------------------------------------------------------------
	localparam logic [2:0] CRL_STATE_OFF      = 3'h4;
	localparam logic [2:0] CRL_STATE_LOW_PWR  = 3'h5;
	localparam logic [1:0] CRL_SEL_LOW_VOLT   = 2'h0;
	localparam logic [1:0] CRL_SEL_HIGH_VOLT  = 2'h1;
	localparam logic [2:0] CRL_APPLIED_RESET  = 3'h4;
	localparam logic       CRL_SEL_RESET      = 1'b0;

	// -----------------------------------------------------------------
	// Serial frame
	// -----------------------------------------------------------------
	localparam logic [4:0] CRL_BITS_CMD   = 5'h08;
	localparam logic [4:0] CRL_BITS_FRAME = 5'h10;

	typedef enum logic {
		CRL_PH_CMD,
		CRL_PH_DATA
	} crl_phase_t;

endpackage

// ---- logic/crl_spi_slave.sv ----
// Serial slave that turns host frames into register reads and writes.
`timescale 1ns/1ps
module crl_spi_slave
	import crl_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic       sclk_i,
	input  wire logic       cs_n_i,
	input  wire logic       mosi_i,
	input  wire logic [7:0] rdata_i,
	output logic [6:0]      rd_addr_o,
	output logic            miso_o,
	output logic            wr_o,
	output logic [6:0]      wr_addr_o,
	output logic [7:0]      wr_data_o
);

	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	logic [2:0] sclk_q, sclk_d;
	logic [1:0] cs_q, cs_d;
	logic [1:0] mosi_q, mosi_d;

	always_comb begin
		sclk_d = {sclk_q[1:0], sclk_i};
		cs_d   = {cs_q[0], cs_n_i};
		mosi_d = {mosi_q[0], mosi_i};
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_q <= 3'h0;
			cs_q   <= 2'h3;
			mosi_q <= 2'h0;
		end else begin
			sclk_q <= sclk_d;
			cs_q   <= cs_d;
			mosi_q <= mosi_d;
		end
	end

	// -----------------------------------------------------------------
	// Frame engine
	// -----------------------------------------------------------------
	logic       rise, fall, active;
	logic [4:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] out_q, out_d;
	logic [6:0] addr_q, addr_d;
	logic       write_q, write_d;
	logic       miso_q, miso_d;
	logic       wr_q, wr_d;
	logic [6:0] wa_q, wa_d;
	logic [7:0] wd_q, wd_d;
	crl_phase_t ph_q, ph_d;

	assign rise   = sclk_q[1] & ~sclk_q[2];
	assign fall   = ~sclk_q[1] & sclk_q[2];
	assign active = ~cs_q[1];
	assign rd_addr_o = {sh_q[5:0], mosi_q[1]};

	always_comb begin
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		out_d   = out_q;
		addr_d  = addr_q;
		write_d = write_q;
		miso_d  = miso_q;
		ph_d    = ph_q;
		wr_d    = 1'b0;
		wa_d    = wa_q;
		wd_d    = wd_q;
		if (!active) begin
			cnt_d  = 5'h00;
			ph_d   = CRL_PH_CMD;
			miso_d = 1'b0;
		end else if (rise) begin
			sh_d  = {sh_q[6:0], mosi_q[1]};
			cnt_d = cnt_q + 5'h01;
			if (cnt_d == CRL_BITS_CMD) begin
				write_d = sh_q[6];
				addr_d  = rd_addr_o;
				out_d   = rdata_i;
				ph_d    = CRL_PH_DATA;
			end else if (cnt_d == CRL_BITS_FRAME) begin
				// A frame longer than sixteen clocks starts over as a new command byte.
				cnt_d = 5'h00;
				ph_d  = CRL_PH_CMD;
				wr_d  = write_q;
				wa_d  = addr_q;
				wd_d  = {sh_q[6:0], mosi_q[1]};
			end
		end else if (fall && ph_q == CRL_PH_DATA) begin
			miso_d = out_q[7];
			out_d  = {out_q[6:0], 1'b0};
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q   <= 5'h00;
			sh_q    <= 8'h00;
			out_q   <= 8'h00;
			addr_q  <= 7'h00;
			write_q <= 1'b0;
			miso_q  <= 1'b0;
			ph_q    <= CRL_PH_CMD;
			wr_q    <= 1'b0;
			wa_q    <= 7'h00;
			wd_q    <= 8'h00;
		end else begin
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			out_q   <= out_d;
			addr_q  <= addr_d;
			write_q <= write_d;
			miso_q  <= miso_d;
			ph_q    <= ph_d;
			wr_q    <= wr_d;
			wa_q    <= wa_d;
			wd_q    <= wd_d;
		end
	end

	assign miso_o    = miso_q;
	assign wr_o      = wr_q;
	assign wr_addr_o = wa_q;
	assign wr_data_o = wd_q;

endmodule

// ---- logic/crl_rail_regs.sv ----
// Communication-rail control registers and their mapping onto the two LDOs.
`timescale 1ns/1ps
module crl_rail_regs
	import crl_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic sclk_i,
	input  wire logic cs_n_i,
	input  wire logic mosi_i,
	input  wire logic standby_exit_pin_i,
	output logic      miso_o,
	output logic      pos_ldo_en_o,
	output logic      pos_ldo_low_power_o,
	output logic      pos_ldo_1p3_o,
	output logic      wifi_ldo_en_o,
	output logic      wifi_ldo_low_power_o,
	output logic      wifi_ldo_2p5_o,
	output logic      buck_1p5_raise_o
);

	// -----------------------------------------------------------------
	// Serial access
	// -----------------------------------------------------------------
	logic [6:0] rd_addr;
	logic [7:0] rdata;
	logic       wr;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;

	crl_spi_slave u_spi (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.sclk_i     (sclk_i),
		.cs_n_i     (cs_n_i),
		.mosi_i     (mosi_i),
		.rdata_i    (rdata),
		.rd_addr_o  (rd_addr),
		.miso_o     (miso_o),
		.wr_o       (wr),
		.wr_addr_o  (wr_addr),
		.wr_data_o  (wr_data)
	);

	// -----------------------------------------------------------------
	// Standby exit pin synchroniser and edge detect
	// -----------------------------------------------------------------
	logic [2:0] exit_q, exit_d;
	logic       exit_rise;

	always_comb begin
		exit_d = {exit_q[1:0], standby_exit_pin_i};
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			exit_q <= 3'h0;
		end else begin
			exit_q <= exit_d;
		end
	end

	assign exit_rise = exit_q[1] & ~exit_q[2];

	// -----------------------------------------------------------------
	// Control registers
	// -----------------------------------------------------------------
	logic [7:0] io_rail_ctrl_reg_q, io_rail_ctrl_reg_d;
	logic [7:0] radio_rail_ctrl_reg_q, radio_rail_ctrl_reg_d;

	// Codes below four carry no copy request, so only the top bit is tested.
	function automatic logic [7:0] crl_exit_copy(input logic [7:0] r);
		logic [7:0] v;
		v = r;
		if (r[CRL_EXIT_MSB]) begin
			v[CRL_STATE_MSB:CRL_STATE_LSB] = r[CRL_EXIT_MSB:CRL_EXIT_LSB];
		end
		return v;
	endfunction

	always_comb begin
		io_rail_ctrl_reg_d    = io_rail_ctrl_reg_q;
		radio_rail_ctrl_reg_d = radio_rail_ctrl_reg_q;
		if (wr && wr_addr == CRL_IO_RAIL_OFFSET) begin
			io_rail_ctrl_reg_d = wr_data;
		end
		if (wr && wr_addr == CRL_RADIO_RAIL_OFFSET) begin
			radio_rail_ctrl_reg_d = wr_data;
		end
		// The pin copy is applied after a same-cycle write, so the exit event is never lost.
		if (exit_rise) begin
			io_rail_ctrl_reg_d    = crl_exit_copy(io_rail_ctrl_reg_d);
			radio_rail_ctrl_reg_d = crl_exit_copy(radio_rail_ctrl_reg_d);
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			io_rail_ctrl_reg_q    <= CRL_IO_RAIL_RESET;
			radio_rail_ctrl_reg_q <= CRL_RADIO_RAIL_RESET;
		end else begin
			io_rail_ctrl_reg_q    <= io_rail_ctrl_reg_d;
			radio_rail_ctrl_reg_q <= radio_rail_ctrl_reg_d;
		end
	end

	always_comb begin
		if (rd_addr == CRL_IO_RAIL_OFFSET) begin
			rdata = io_rail_ctrl_reg_q;
		end else if (rd_addr == CRL_RADIO_RAIL_OFFSET) begin
			rdata = radio_rail_ctrl_reg_q;
		end else begin
			rdata = CRL_UNMAPPED_READ;
		end
	end

	// -----------------------------------------------------------------
	// Applied state and mapping
	// -----------------------------------------------------------------
	logic [2:0] io_st_q, io_st_d, rad_st_q, rad_st_d;
	logic       io_sel_q, io_sel_d, rad_sel_q, rad_sel_d;

	always_comb begin
		io_st_d   = io_st_q;
		rad_st_d  = rad_st_q;
		io_sel_d  = io_sel_q;
		rad_sel_d = rad_sel_q;
		// Reserved codes are stored for readback yet never reach the regulators.
		if (io_rail_ctrl_reg_q[CRL_STATE_MSB]) begin
			io_st_d = io_rail_ctrl_reg_q[CRL_STATE_MSB:CRL_STATE_LSB];
		end
		if (radio_rail_ctrl_reg_q[CRL_STATE_MSB]) begin
			rad_st_d = radio_rail_ctrl_reg_q[CRL_STATE_MSB:CRL_STATE_LSB];
		end
		if (io_rail_ctrl_reg_q[CRL_SEL_MSB:CRL_SEL_LSB] == CRL_SEL_LOW_VOLT ||
			io_rail_ctrl_reg_q[CRL_SEL_MSB:CRL_SEL_LSB] == CRL_SEL_HIGH_VOLT) begin
			io_sel_d = io_rail_ctrl_reg_q[CRL_SEL_LSB];
		end
		if (radio_rail_ctrl_reg_q[CRL_SEL_MSB:CRL_SEL_LSB] == CRL_SEL_LOW_VOLT ||
			radio_rail_ctrl_reg_q[CRL_SEL_MSB:CRL_SEL_LSB] == CRL_SEL_HIGH_VOLT) begin
			rad_sel_d = radio_rail_ctrl_reg_q[CRL_SEL_LSB];
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			io_st_q   <= CRL_APPLIED_RESET;
			rad_st_q  <= CRL_APPLIED_RESET;
			io_sel_q  <= CRL_SEL_RESET;
			rad_sel_q <= CRL_SEL_RESET;
		end else begin
			io_st_q   <= io_st_d;
			rad_st_q  <= rad_st_d;
			io_sel_q  <= io_sel_d;
			rad_sel_q <= rad_sel_d;
		end
	end

	// -----------------------------------------------------------------
	// Regulator outputs
	// -----------------------------------------------------------------
	logic [2:0] pos_st, wifi_st;
	logic       pos_1p3, wifi_2p5;
	logic [6:0] out_q, out_d;

	// Conflicting mappings are not arbitrated; the io rail simply takes precedence.
	always_comb begin
		pos_st   = CRL_STATE_OFF;
		wifi_st  = CRL_STATE_OFF;
		pos_1p3  = 1'b0;
		wifi_2p5 = 1'b0;
		if (rad_sel_q) begin
			pos_st  = rad_st_q;
			pos_1p3 = 1'b1;
		end else begin
			wifi_st = rad_st_q;
		end
		if (!io_sel_q) begin
			pos_st  = io_st_q;
			pos_1p3 = 1'b0;
		end else begin
			wifi_st  = io_st_q;
			wifi_2p5 = 1'b1;
		end
		out_d[0] = pos_st != CRL_STATE_OFF;
		out_d[1] = pos_st == CRL_STATE_LOW_PWR;
		out_d[2] = pos_1p3;
		out_d[3] = wifi_st != CRL_STATE_OFF;
		out_d[4] = wifi_st == CRL_STATE_LOW_PWR;
		out_d[5] = wifi_2p5;
		out_d[6] = pos_1p3;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_q <= 7'h00;
		end else begin
			out_q <= out_d;
		end
	end

	assign pos_ldo_en_o         = out_q[0];
	assign pos_ldo_low_power_o  = out_q[1];
	assign pos_ldo_1p3_o        = out_q[2];
	assign wifi_ldo_en_o        = out_q[3];
	assign wifi_ldo_low_power_o = out_q[4];
	assign wifi_ldo_2p5_o       = out_q[5];
	assign buck_1p5_raise_o     = out_q[6];

endmodule

// ---- sim/crl_host_model.sv ----
// Host serial controller model that drives mode-0 frames into the block.
`timescale 1ns/1ps
module crl_host_model (
	input  wire logic core_clk_i,
	input  wire logic miso_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// Six core cycles per half period leave room for the read data path.
	task automatic half();
		repeat (6) @(posedge core_clk_i);
		#1;
	endtask

	task automatic xfer(input logic [15:0] frm, output logic [7:0] rd);
		half();
		cs_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi_o = frm[i];
			half();
			sclk_o = 1'b1;
			rd = {rd[6:0], miso_i};
			half();
			sclk_o = 1'b0;
		end
		half();
		cs_n_o = 1'b1;
		// A released line must not keep showing its last bit.
		mosi_o = ~mosi_o;
	endtask

	// A frame cut short by chip select must never reach the registers.
	task automatic cut(input logic [15:0] frm, input int n);
		half();
		cs_n_o = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			mosi_o = frm[i];
			half();
			sclk_o = 1'b1;
			half();
			sclk_o = 1'b0;
		end
		half();
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
	endtask
endmodule

// ---- sim/crl_rail_regs_monitor.sv ----
// Checker on the ports of the rail mapping block.
`timescale 1ns/1ps
module crl_rail_regs_monitor (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	input wire logic standby_exit_pin_i,
	input wire logic miso_o,
	input wire logic pos_ldo_en_o,
	input wire logic pos_ldo_low_power_o,
	input wire logic pos_ldo_1p3_o,
	input wire logic wifi_ldo_en_o,
	input wire logic wifi_ldo_low_power_o,
	input wire logic wifi_ldo_2p5_o,
	input wire logic buck_1p5_raise_o
);
	logic [6:0] outs;
	assign outs = {pos_ldo_en_o, pos_ldo_low_power_o, pos_ldo_1p3_o, wifi_ldo_en_o,
		wifi_ldo_low_power_o, wifi_ldo_2p5_o, buck_1p5_raise_o};

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	// Eight quiet cycles cover the pin synchronisers and both output stages.
	sequence quiet_s;
		(cs_n_i && !standby_exit_pin_i) [*8];
	endsequence

	buck_track_a: assert property (buck_1p5_raise_o == pos_ldo_1p3_o)
		else $error("buck raise differs from positioning voltage");
	release_zero_a: assert property ($fell(rst_i) |-> outs == 7'h00)
		else $error("outputs not idle after reset");
	reset_hold_a: assert property (disable iff (1'b0) rst_i |-> outs == 7'h00)
		else $error("outputs active during reset");
	miso_idle_a: assert property (cs_n_i [*6] |-> !miso_o)
		else $error("serial output busy while deselected");
	pos_lp_a: assert property (pos_ldo_low_power_o |-> pos_ldo_en_o)
		else $error("positioning low power while off");
	wifi_lp_a: assert property (wifi_ldo_low_power_o |-> wifi_ldo_en_o)
		else $error("wireless low power while off");
	state_hold_a: assert property (quiet_s |=> $stable(outs[6:5]) && $stable(outs[3:2]))
		else $error("rail state moved without cause");
	volt_hold_a: assert property (quiet_s |=> $stable({pos_ldo_1p3_o, wifi_ldo_2p5_o}))
		else $error("rail voltage moved without cause");
endmodule

// ---- sim/crl_rail_regs_tb_top.sv ----
// Top-level bench for the communication-rail mapping registers.
`timescale 1ns/1ps
module crl_rail_regs_tb_top;
	import crl_pkg::*;
	logic       core_clk_i, rst_i, sclk_i, cs_n_i, mosi_i, standby_exit_pin_i;
	logic       miso_o, pos_ldo_en_o, pos_ldo_low_power_o, pos_ldo_1p3_o;
	logic       wifi_ldo_en_o, wifi_ldo_low_power_o, wifi_ldo_2p5_o, buck_1p5_raise_o;
	logic [2:0] io_st, rad_st;
	logic       io_sel, rad_sel;
	logic [7:0] io_q, rad_q, rd;
	int         errors = 0;
	int         num_checks = 0;
	wire  [6:0] outs = {pos_ldo_en_o, pos_ldo_low_power_o, pos_ldo_1p3_o, wifi_ldo_en_o,
		wifi_ldo_low_power_o, wifi_ldo_2p5_o, buck_1p5_raise_o};
	// Each pair maps the two registers onto different LDOs.
	localparam logic [15:0] TBL [4] = '{16'h0506, 16'h4744, 16'h4445, 16'h0607};

	crl_rail_regs DUT (.*);
	crl_host_model u_host (.core_clk_i(core_clk_i), .miso_i(miso_o), .sclk_o(sclk_i),
		.cs_n_o(cs_n_i), .mosi_o(mosi_i));

	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// An unmapped LDO stays off at its default voltage.
	function automatic logic [6:0] exp_ldo();
		logic [2:0] p;
		logic [2:0] w;
		p = io_sel ? (rad_sel ? rad_st : 3'h4) : io_st;
		w = io_sel ? io_st : (rad_sel ? 3'h4 : rad_st);
		return {p > 3'h4, p == 3'h5, rad_sel & io_sel, w > 3'h4, w == 3'h5, io_sel, rad_sel & io_sel};
	endfunction

	task automatic chk_ldo();
		tick(2);
		chk8({1'b0, outs}, {1'b0, exp_ldo()});
	endtask

	task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
		u_host.xfer({1'b0, a, 8'h00}, rd);
		chk8(rd, exp);
	endtask

	// Reserved codes are stored but the applied fields keep their last valid value.
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		u_host.xfer({1'b1, a, d}, rd);
		if (a == CRL_IO_RAIL_OFFSET) begin
			io_q = d;
			if (d[2]) io_st = d[2:0];
			if (!d[7]) io_sel = d[6];
		end
		if (a == CRL_RADIO_RAIL_OFFSET) begin
			rad_q = d;
			if (d[2]) rad_st = d[2:0];
			if (!d[7]) rad_sel = d[6];
		end
	endtask

	task automatic exit_pulse();
		standby_exit_pin_i = 1'b1;
		tick(4);
		standby_exit_pin_i = 1'b0;
		tick(8);
	endtask

	task automatic do_reset();
		rst_i = 1'b1;
		{io_st, rad_st, io_sel, rad_sel} = {CRL_APPLIED_RESET, CRL_APPLIED_RESET, 2'b00};
		io_q = CRL_IO_RAIL_RESET;
		rad_q = CRL_RADIO_RAIL_RESET;
		tick(2);
		rst_i = 1'b0;
	endtask

	// About thirty-five frames of some two hundred cycles each; nearly three times that is allowed.
	initial begin
		#2000000;
		errors++;
		close_out();
	end

	initial begin
		standby_exit_pin_i = 1'b0;
		do_reset();
		chk_ldo();
		rdchk(CRL_IO_RAIL_OFFSET, 8'h24);
		rdchk(CRL_RADIO_RAIL_OFFSET, 8'h24);
		for (int i = 0; i < 4; i++) begin
			wr(CRL_IO_RAIL_OFFSET, TBL[i][15:8]);
			wr(CRL_RADIO_RAIL_OFFSET, TBL[i][7:0]);
			chk_ldo();
			rdchk(CRL_IO_RAIL_OFFSET, io_q);
			rdchk(CRL_RADIO_RAIL_OFFSET, rad_q);
		end
		wr(CRL_IO_RAIL_OFFSET, 8'h82);
		chk_ldo();
		rdchk(CRL_IO_RAIL_OFFSET, 8'h82);
		wr(CRL_IO_RAIL_OFFSET, 8'h2C);
		wr(CRL_RADIO_RAIL_OFFSET, 8'h1E);
		chk_ldo();
		exit_pulse();
		io_st = 3'h5;
		io_q = 8'h2D;
		chk_ldo();
		rdchk(CRL_IO_RAIL_OFFSET, io_q);
		rdchk(CRL_RADIO_RAIL_OFFSET, rad_q);
		wr(CRL_RADIO_RAIL_OFFSET, 8'hF5);
		chk_ldo();
		exit_pulse();
		rad_st = 3'h6;
		rad_q = 8'hF6;
		chk_ldo();
		rdchk(CRL_RADIO_RAIL_OFFSET, rad_q);
		rdchk(CRL_IO_RAIL_OFFSET, io_q);
		u_host.cut({1'b1, CRL_IO_RAIL_OFFSET, 8'hFF}, 15);
		rdchk(CRL_IO_RAIL_OFFSET, io_q);
		chk_ldo();
		wr(7'h4C, 8'hFF);
		rdchk(7'h4C, CRL_UNMAPPED_READ);
		rdchk(CRL_IO_RAIL_OFFSET, io_q);
		do_reset();
		chk_ldo();
		rdchk(CRL_RADIO_RAIL_OFFSET, 8'h24);
		close_out();
	end
endmodule

bind crl_rail_regs crl_rail_regs_monitor u_mon (.*);
